// ### bench/tweep_core_tb.sv
// Self-checking bench for the serial EEPROM command front end.
// Assumes tweep_pkg, tweep_core and tweep_host are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tweep_core_tb;
   import tweep_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic sel_w;
   logic sclk_w;
   logic sdin_w;
   logic strap = 1'b1;
   logic dout;
   logic oe;
   wire logic dout_w;
   logic [31:0] rx;
   logic [31:0] rd;
   int err_total = 0;
   int tests_run = 0;

   // Clock of 4 ns and data-out pulled up when released.
   always #2 clk_i = ~clk_i;
   assign dout_w = oe ? dout : 1'b1;

   tweep_core #(.PROG_CYCLES(400)) u_tweep_core (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .select_i(sel_w),
      .serial_clock_i(sclk_w), .serial_data_in_i(sdin_w),
      .width_strap_i(strap), .data_out_o(dout), .data_out_oe_o(oe));
   tweep_host u_tweep_host (.clk_i(clk_i), .select_o(sel_w),
      .serial_clock_o(sclk_w), .serial_data_in_o(sdin_w),
      .data_out_i(dout_w));

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   // One classic Wishbone cycle, held until ack is seen.
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i) {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      // Reads right after an edge see the values sampled at that edge.
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         err_total++;
         print_verdict();
      end else begin
         r = rdat;
         {cyc, stb, we} <= 3'b000;
      end
   endtask

   // Frame, then select low time with data-out released.
   task automatic cmd(input int n, input logic [47:0] b);
      u_tweep_host.frame(n, b, rx);
      repeat (4) @(posedge clk_i);
      cmp("oe_idle", 32'h0, {31'h0, oe});
   endtask

   // Polls status: busy low first, then ready high in a bounded wait.
   task automatic prog(input int lo);
      int n;
      n = 0;
      u_tweep_host.sel(1'b1);
      repeat (3) @(negedge clk_i);
      cmp("busy", 32'h2, {30'h0, oe, dout});
      while (dout !== 1'b1 && n < 600) begin
         @(negedge clk_i);
         n++;
      end
      cmp("ready", 32'h1, {31'h0, n >= lo && n <= 410});
      if (n >= 600) print_verdict();
      u_tweep_host.sel(1'b0);
      repeat (4) @(posedge clk_i);
   endtask

   task automatic rd16(input logic [9:0] a, input logic [15:0] e);
      cmd(29, {3'b110, a, 16'h0});
      cmp("rd16", {15'h0, 1'b0, e}, {15'h0, rx[16:0]});
   endtask

   // Main sequence.
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_STATUS, 32'h0, rd);
      cmp("status", 32'h4, rd);
      wb(1'b0, 4'h8, 32'h0, rd);
      cmp("unmapped", 32'h0, rd);
      cmd(32, {3'b000, 3'b101, 10'h005, 16'h1234});
      rd16(10'h005, 16'hFFFF);
      cmd(13, {5'b10011, 8'h00});
      wb(1'b0, REG_STATUS, 32'h0, rd);
      cmp("status", 32'h5, rd);
      cmd(29, {3'b101, 10'h005, 16'hA5C3});
      prog(350);
      cmd(29, {3'b101, 10'h006, 16'h0F0E});
      prog(350);
      cmd(45, {3'b110, 10'h005, 32'h0});
      cmp("stream", 32'hA5C30F0E, rx);
      cmd(13, {3'b111, 10'h006});
      prog(350);
      rd16(10'h006, 16'hFFFF);
      cmd(29, {5'b10001, 8'h00, 16'h1357});
      prog(350);
      rd16(10'h3FF, 16'h1357);
      cmd(13, {5'b10010, 8'h00});
      prog(350);
      rd16(10'h000, 16'hFFFF);
      strap <= 1'b0;
      cmd(22, {3'b101, 11'h007, 8'h5A});
      prog(350);
      cmd(22, {3'b110, 11'h007, 8'h00});
      cmp("rd8", 32'h05A, {23'h0, rx[8:0]});
      wb(1'b0, REG_STATUS, 32'h0, rd);
      cmp("status", 32'h1, rd);
      strap <= 1'b1;
      cmd(29, {3'b101, 10'h001, 16'h1111});
      u_tweep_host.frame(13, {3'b111, 10'h001}, rx);
      prog(0);
      rd16(10'h001, 16'h1111);
      rd16(10'h003, 16'hFF5A);
      cmd(13, {5'b10000, 8'h00});
      cmd(29, {3'b101, 10'h003, 16'h0000});
      rd16(10'h003, 16'hFF5A);
      cmd(13, {5'b10011, 8'h00});
      cmd(29, {3'b101, 10'h002, 16'h2468});
      repeat (410) @(posedge clk_i);
      rd16(10'h002, 16'h2468);
      wb(1'b1, REG_CTRL, 32'h1, rd);
      wb(1'b0, REG_STATUS, 32'h0, rd);
      cmp("status", 32'h4, rd);
      print_verdict();
   end
endmodule // tweep_core_tb

`default_nettype wire

// ### bench/tweep_host.sv
// Host model that drives select, serial clock and data-in of the device.
// Assumes the bench resolves data-out with a pull-up before it gets here.
`timescale 1ns/1ns
`default_nettype none

module tweep_host (
   // Clock.
   input wire logic clk_i,
   // Serial pins.
   output logic select_o,
   output logic serial_clock_o,
   output logic serial_data_in_o,
   input wire logic data_out_i
);
   // All lines idle low at time zero.
   initial begin
      select_o = 1'b0;
      serial_clock_o = 1'b0;
      serial_data_in_o = 1'b0;
   end

   // Holds select at a level, used for status polling.
   task automatic sel(input logic v);
      @(posedge clk_i) select_o <= v;
      serial_data_in_o <= 1'b0;
   endtask

   // Sends one frame of n bits, three clk cycles a level, keeps the
   // last 32 bits seen on data-out after each rise.
   task automatic frame(input int n, input logic [47:0] bits,
                        output logic [31:0] rx);
      rx = 32'h0;
      @(posedge clk_i) select_o <= 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_i) serial_clock_o <= 1'b0;
         serial_data_in_o <= bits[i];
         repeat (2) @(posedge clk_i);
         @(posedge clk_i) serial_clock_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         @(negedge clk_i) rx = {rx[30:0], data_out_i};
      end
      // Release: data line flips so a stale level is never trusted.
      @(posedge clk_i) serial_clock_o <= 1'b0;
      select_o <= 1'b0;
      serial_data_in_o <= ~serial_data_in_o;
   endtask
endmodule // tweep_host

`default_nettype wire

// ### hw/tweep_core.sv
// Command front end and storage array of a three-wire serial EEPROM.
// Assumes select, serial clock and data-in are synchronous to clk_i and
// that the pad logic resolves data_out_o with data_out_oe_o.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - A frame starts at the first one sampled after select rises.
// - Zeros sampled before the start bit are ignored.
// - Sixteen-bit mode uses a ten-bit address, A9 down to A0.
// - Sixteen-bit mode uses sixteen-bit data words, D15 first.
// - Sixteen-bit frames: 29 clocks with data, 13 without.
// - Eight-bit mode: eleven-bit address, byte data, 22 or 14 clocks.
// - Opcode 10 reads, 01 writes, 11 erases, 00 selects extended commands.
// - Extended: 11 unlock, 00 lock, 01 fill-all, 10 clear-all.
// - A dummy zero leaves on the clock sampling A0, then the word.
// - Further clocks during a read stream the following addresses.
// - Writing starts at select fall after the last data bit.
// - No command is accepted while status shows busy.
// - Write and fill-all erase internally before programming.
// - Fill-all programs every location in one 5 ms bulk cycle.
// - Power-up clears write enable; programming needs a prior unlock.
// - Write enable stays set until lock, power removal or a software power-on clear.
// - Reads execute whatever the write enable state.
// - Strap high selects sixteen-bit words, low selects bytes.
// - Data-in is sampled on each serial clock rising edge.
// - Status reads low while programming, high when done.
module tweep_core
   import tweep_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DEF,
   parameter int MEM_BYTES = MEM_BYTES_DEF
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial pins.
   input wire logic select_i,
   input wire logic serial_clock_i,
   input wire logic serial_data_in_i,
   input wire logic width_strap_i,
   output logic data_out_o,
   output logic data_out_oe_o
);

   localparam int PCW = $clog2(PROG_CYCLES + 1);
   localparam logic [PCW-1:0] PROG_LOAD = PCW'(PROG_CYCLES);
   localparam logic [PCW-1:0] PROG_LAST = PCW'(1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tweep_state_t state_reg, state_next;
   tweep_pg_t pg_reg, pg_next;
   logic sclk_q_reg;
   logic sel_q_reg;
   logic x16_reg, x16_next;
   logic wen_reg, wen_next;
   logic stat_en_reg, stat_en_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [12:0] hdr_reg, hdr_next;
   logic [10:0] addr_reg, addr_next;
   logic [15:0] data_reg, data_next;
   logic [15:0] word_reg, word_next;
   logic [PCW-1:0] prog_reg, prog_next;
   logic dout_reg, dout_next;
   logic oe_reg, oe_next;
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [7:0] mem_reg [MEM_BYTES];
   logic [7:0] mem_next [MEM_BYTES];

   // Decode helpers shared by the sequencer and the checks.
   logic rise;
   logic sel_fall;
   logic busy;
   logic commit;
   logic pwr_clr;
   logic [12:0] hdr_new;
   logic hdr_done;
   logic [1:0] opc_new;
   logic [1:0] ext_new;
   logic [10:0] adr_new;
   logic [10:0] adr_inc;
   logic [4:0] data_bits;

   // ----------------------------------------------------------------
   // Word fetch
   // ----------------------------------------------------------------
   // Returns the addressed word left aligned, so bit 15 leaves first.
   function automatic logic [15:0] fetch(input logic [10:0] a,
                                         input logic x16);
      logic [10:0] hi;
      hi = {a[9:0], 1'b0};
      if (x16) begin
         fetch = {mem_reg[hi], mem_reg[hi | 11'h001]};
      end else begin
         fetch = {mem_reg[a], 8'h00};
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------
   // Pins are sampled on clk_i; a rise is seen one edge after it occurs.
   assign rise = serial_clock_i & ~sclk_q_reg;
   assign sel_fall = sel_q_reg & ~select_i;
   assign busy = (prog_reg != '0);
   assign commit = (prog_reg == PROG_LAST);
   assign hdr_new = {hdr_reg[11:0], serial_data_in_i};
   assign hdr_done = (cnt_reg + 5'h01) ==
                     (x16_reg ? HDR_BITS_X16 : HDR_BITS_X8);
   assign opc_new = x16_reg ? hdr_new[11:10] : hdr_new[12:11];
   assign ext_new = x16_reg ? hdr_new[9:8] : hdr_new[10:9];
   assign adr_new = x16_reg ? {1'b0, hdr_new[9:0]} : hdr_new[10:0];
   assign adr_inc = x16_reg ? {1'b0, addr_reg[9:0] + 10'h001}
                            : addr_reg + 11'h001;
   assign data_bits = x16_reg ? DATA_BITS_X16 : DATA_BITS_X8;

   // ----------------------------------------------------------------
   // Serial sequencer
   // ----------------------------------------------------------------
   // Decodes each frame and drives data-out from the next-state values.
   always_comb begin
      state_next = state_reg;
      pg_next = pg_reg;
      x16_next = x16_reg;
      wen_next = wen_reg;
      stat_en_next = stat_en_reg;
      cnt_next = cnt_reg;
      hdr_next = hdr_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      word_next = word_reg;
      prog_next = prog_reg;
      dout_next = dout_reg;
      oe_next = oe_reg;
      // The program timer runs down and frees the array at zero.
      if (busy) begin
         prog_next = prog_reg - PROG_LAST;
      end
      // The strap is only taken while the device is deselected.
      if (!select_i) begin
         x16_next = width_strap_i;
      end
      // A power-on clear from software drops the enable first.
      if (pwr_clr) begin
         wen_next = 1'b0;
      end
      if (!select_i) begin
         state_next = ST_IDLE;
         cnt_next = 5'h00;
         // Deferred commands fire on the select fall, and only enabled.
         if (sel_fall && state_reg == ST_ARMED && wen_reg && !busy) begin
            prog_next = PROG_LOAD;
            stat_en_next = 1'b1;
         end
      end else if (rise) begin
         case (state_reg)
            ST_IDLE: begin
               // Leading zeros and any bit during busy are dropped.
               if (serial_data_in_i && !busy) begin
                  state_next = ST_HDR;
                  stat_en_next = 1'b0;
                  cnt_next = 5'h00;
                  hdr_next = 13'h0000;
               end
            end
            ST_HDR: begin
               hdr_next = hdr_new;
               cnt_next = cnt_reg + 5'h01;
               if (hdr_done) begin
                  cnt_next = 5'h00;
                  addr_next = adr_new;
                  case (opc_new)
                     OPC_READ: begin
                        // Dummy zero on the A0 clock, then the word.
                        state_next = ST_READ;
                        word_next = fetch(adr_new, x16_reg);
                        dout_next = 1'b0;
                        oe_next = 1'b1;
                     end
                     OPC_WRITE: begin
                        state_next = ST_DATA;
                        pg_next = PG_WORD;
                     end
                     OPC_ERASE: begin
                        state_next = ST_ARMED;
                        pg_next = PG_ERASE;
                     end
                     default: begin
                        case (ext_new)
                           EXT_UNLOCK: begin
                              state_next = ST_HOLD;
                              wen_next = 1'b1;
                           end
                           EXT_LOCK: begin
                              state_next = ST_HOLD;
                              wen_next = 1'b0;
                           end
                           EXT_FILL: begin
                              state_next = ST_DATA;
                              pg_next = PG_FILL;
                           end
                           default: begin
                              state_next = ST_ARMED;
                              pg_next = PG_CLEAR;
                           end
                        endcase
                     end
                  endcase
               end
            end
            ST_DATA: begin
               data_next = {data_reg[14:0], serial_data_in_i};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg + 5'h01 == data_bits) begin
                  state_next = ST_ARMED;
               end
            end
            ST_READ: begin
               // Shift out MSB first and refetch past the last bit.
               dout_next = word_reg[15];
               word_next = {word_reg[14:0], 1'b0};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg + 5'h01 == data_bits) begin
                  cnt_next = 5'h00;
                  addr_next = adr_inc;
                  word_next = fetch(adr_inc, x16_reg);
               end
            end
            ST_ARMED, ST_HOLD: begin
               state_next = state_reg;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
      // Data-out drives only read data or status while selected.
      if (!select_i) begin
         oe_next = 1'b0;
      end else if (state_next == ST_IDLE && stat_en_next) begin
         oe_next = 1'b1;
         dout_next = (prog_next == '0);
      end else if (state_next != ST_READ) begin
         oe_next = 1'b0;
      end
   end

   // Registers the sequencer state; power-on leaves writes disabled.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         pg_reg <= PG_WORD;
         sclk_q_reg <= 1'b0;
         sel_q_reg <= 1'b0;
         x16_reg <= 1'b1;
         wen_reg <= 1'b0;
         stat_en_reg <= 1'b0;
         cnt_reg <= 5'h00;
         hdr_reg <= 13'h0000;
         addr_reg <= 11'h000;
         data_reg <= 16'h0000;
         word_reg <= 16'h0000;
         prog_reg <= '0;
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pg_reg <= pg_next;
         sclk_q_reg <= serial_clock_i;
         sel_q_reg <= select_i;
         x16_reg <= x16_next;
         wen_reg <= wen_next;
         stat_en_reg <= stat_en_next;
         cnt_reg <= cnt_next;
         hdr_reg <= hdr_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         word_reg <= word_next;
         prog_reg <= prog_next;
         dout_reg <= dout_next;
         oe_reg <= oe_next;
      end
   end

   assign data_out_o = dout_reg;
   assign data_out_oe_o = oe_reg;

   // ----------------------------------------------------------------
   // Storage array
   // ----------------------------------------------------------------
   // Each byte is overwritten, never merged, at the end of a cycle.
   for (genvar g = 0; g < MEM_BYTES; g++) begin : g_byte
      localparam logic [10:0] BI = 11'(g);
      logic hit;
      assign hit = x16_reg ? (BI[10:1] == addr_reg[9:0]) : (BI == addr_reg);
      always_comb begin
         mem_next[g] = mem_reg[g];
         if (commit) begin
            case (pg_reg)
               PG_WORD: begin
                  if (hit) begin
                     mem_next[g] = (x16_reg && !BI[0]) ? data_reg[15:8]
                                                       : data_reg[7:0];
                  end
               end
               PG_ERASE: begin
                  if (hit) begin
                     mem_next[g] = ERASED_BYTE;
                  end
               end
               PG_FILL: begin
                  mem_next[g] = (x16_reg && !BI[0]) ? data_reg[15:8]
                                                    : data_reg[7:0];
               end
               default: begin
                  mem_next[g] = ERASED_BYTE;
               end
            endcase
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mem_reg[g] <= ERASED_BYTE;
         end else begin
            mem_reg[g] <= mem_next[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   // One wait state; unmapped offsets answer with zero.
   always_comb begin
      ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
      rdat_next = rdat_reg;
      pwr_clr = ack_next & wb_we_i & wb_sel_i[0] &
                (wb_adr_i == REG_CTRL) & wb_dat_i[CTRL_PWR_CLR];
      if (ack_next) begin
         rdat_next = 32'h0000_0000;
         if (wb_adr_i == REG_STATUS) begin
            rdat_next[STAT_WEN] = wen_reg;
            rdat_next[STAT_BUSY] = busy;
            rdat_next[STAT_X16] = x16_reg;
            rdat_next[STAT_STATE_LSB +: 3] = state_reg;
         end
      end
   end

   // Registers the bus answer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start_seen;
      state_reg == ST_IDLE && select_i && rise && serial_data_in_i && !busy;
   endsequence
   sequence s_armed_fall;
      state_reg == ST_ARMED && sel_fall && !busy;
   endsequence

   property p_start_bit;
      s_start_seen |=> state_reg == ST_HDR;
   endproperty
   a_start_bit: assert property (p_start_bit)
      else $error("start bit not taken");

   property p_zero_ignored;
      state_reg == ST_IDLE && select_i && rise && !serial_data_in_i
         |=> state_reg == ST_IDLE && !data_out_oe_o | stat_en_reg;
   endproperty
   a_zero_ignored: assert property (p_zero_ignored)
      else $error("leading zero left idle");

   property p_dummy_bit;
      state_reg == ST_HDR && select_i && rise && hdr_done &&
         opc_new == OPC_READ |=> data_out_oe_o && !data_out_o;
   endproperty
   a_dummy_bit: assert property (p_dummy_bit)
      else $error("dummy zero missing on read");

   property p_program_start;
      s_armed_fall ##0 wen_reg |=> prog_reg == PROG_LOAD;
   endproperty
   a_program_start: assert property (p_program_start)
      else $error("program cycle did not start");

   property p_locked_no_program;
      s_armed_fall ##0 !wen_reg |=> !busy;
   endproperty
   a_locked_no_program: assert property (p_locked_no_program)
      else $error("program ran while locked");

   property p_busy_rejects;
      busy && state_reg == ST_IDLE |=> state_reg == ST_IDLE;
   endproperty
   a_busy_rejects: assert property (p_busy_rejects)
      else $error("command taken while busy");

   property p_status_level;
      state_reg == ST_IDLE && stat_en_reg && data_out_oe_o
         |-> data_out_o == !busy;
   endproperty
   a_status_level: assert property (p_status_level)
      else $error("status level wrong");

   property p_float_deselected;
      !select_i |=> !data_out_oe_o;
   endproperty
   a_float_deselected: assert property (p_float_deselected)
      else $error("data-out driven while deselected");

   property p_busy_ends;
      commit |=> !busy ##1 !busy;
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("busy outlived its cycle");

   property p_wen_holds;
      wen_reg && !pwr_clr && !(state_reg == ST_HDR && hdr_done)
         |=> wen_reg;
   endproperty
   a_wen_holds: assert property (p_wen_holds)
      else $error("write enable dropped");

endmodule // tweep_core

`default_nettype wire

// ### hw/tweep_pkg.sv
// Constants shared by the three-wire serial EEPROM command front end.
// Assumes a single 250 MHz system clock drives all of the logic.
package tweep_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int T_PROG_US = 5000; // Self-timed program cycle, 5 ms.
   localparam int PROG_CYCLES_DEF = T_PROG_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int MEM_BYTES_DEF = 2048;
   localparam logic [4:0] HDR_BITS_X16 = 5'h0C; // Opcode plus 10 address bits.
   localparam logic [4:0] HDR_BITS_X8 = 5'h0D;  // Opcode plus 11 address bits.
   localparam logic [4:0] DATA_BITS_X16 = 5'h10;
   localparam logic [4:0] DATA_BITS_X8 = 5'h08;
   localparam logic [1:0] OPC_EXT = 2'h0;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_READ = 2'h2;
   localparam logic [1:0] OPC_ERASE = 2'h3;
   localparam logic [1:0] EXT_LOCK = 2'h0;
   localparam logic [1:0] EXT_FILL = 2'h1;
   localparam logic [1:0] EXT_CLEAR = 2'h2;
   localparam logic [1:0] EXT_UNLOCK = 2'h3;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int WB_ADR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_PWR_CLR = 0;
   localparam int STAT_WEN = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_X16 = 2;
   localparam int STAT_STATE_LSB = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_HDR = 3'h1,
      ST_DATA = 3'h2,
      ST_READ = 3'h3,
      ST_ARMED = 3'h4,
      ST_HOLD = 3'h5
   } tweep_state_t;

   typedef enum logic [1:0] {
      PG_WORD = 2'h0,
      PG_ERASE = 2'h1,
      PG_FILL = 2'h2,
      PG_CLEAR = 2'h3
   } tweep_pg_t;

endpackage
